// file: hw/gpsds_pkg.sv
// Shared constants for the positioning receiver power and data scheduler
package gpsds_pkg;

  // Clock and one-second tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_S = 1_000_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_S * (NS_PER_S / CLK_PERIOD_NS);
  localparam int TICK_W = 27;

  // Start-up delay: 50 s to 300 s in 10 s steps, selector 0..25
  localparam logic [8:0] DELAY_MIN_S = 9'h032;
  localparam logic [8:0] DELAY_STEP_S = 9'h00a;
  localparam logic [4:0] DELAY_SEL_MAX = 5'h19;

  // Release window: 1 s to 10 s in 1 s steps
  localparam logic [4:0] WINDOW_MIN_S = 5'h01;
  localparam logic [4:0] WINDOW_MAX_S = 5'h0a;

  // Report period: 1 h to 24 h in 1 h steps
  localparam logic [4:0] PERIOD_MIN_H = 5'h01;
  localparam logic [4:0] PERIOD_MAX_H = 5'h18;
  localparam logic [11:0] SEC_PER_HOUR = 12'he10;

  // Counter widths
  localparam int PHASE_W = 9;
  localparam int CYCLE_W = 17;

  // Serial command codes
  localparam logic [2:0] CMD_POWER_ON = 3'h1;
  localparam logic [2:0] CMD_POWER_OFF = 3'h2;
  localparam logic [2:0] CMD_OUTPUT_OPEN = 3'h3;
  localparam logic [2:0] CMD_MODEM_OPEN = 3'h4;
  localparam logic [2:0] CMD_OUTPUT_CLOSE = 3'h5;

  // Data path
  localparam int DATA_W = 8;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  localparam int PORT_EXT = 0;
  localparam int PORT_MODEM = 1;

  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_RADIO,
    ST_DELAY,
    ST_WINDOW,
    ST_SLEEP,
    ST_CMD_ON,
    ST_LOCKED
  } gpsds_state_t;

endpackage

// file: hw/gpsds_top.sv
// Power and data scheduler for an attached positioning receiver
// Functional notes
// (R1) Receiver emits one sentence set per second
// (R2) Output blocked until start-up delay elapsed
// (R3) Start-up delay 50..300 s, 10 s steps
// (R4) Release window 1..10 s, 1 s steps
// (R5) Window end puts receiver to sleep
// (R6) Every wake-up reapplies the full delay
// (R7) Active delay plus window, then sleep
// (R8) Wake-up postponed while radio is busy
// (R9) Report period 1..24 h, hourly steps
// (R10) Five serial commands are accepted
// (R11) Power-on keeps output closed until opened
// (R12) Power-off removes power, position kept
// (R13) Output open only while receiver powered
// (R14) Firmware version selects modem gating command
// (R15) Output close acts only while powered
// (R16) Power removal closes the output path
// (R17) Open command feeds external port only; old firmware also opens modem
// (R18) Modem command forwards data to modem
// (R19) Close resumes schedule with fresh timers
// (R20) After power-off, stay off until open; power-on command also ends it
// (R21) Config flag selects automatic or manual
// (R22) Timers count whole seconds from tick
`timescale 1ns/1ps

module gpsds_top
  import gpsds_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic auto_mode_i,
  input wire logic fw_new_i,
  input wire logic radio_busy_i,
  input wire logic [4:0] startup_delay_sel_i,
  input wire logic [4:0] output_window_length_i,
  input wire logic [4:0] report_period_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_code_i,
  input wire logic rx_valid_i,
  input wire logic [DATA_W-1:0] rx_data_i,
  input wire logic ext_ready_i,
  input wire logic modem_ready_i,
  output logic rx_ready_o,
  output logic ext_valid_o,
  output logic [DATA_W-1:0] ext_data_o,
  output logic modem_valid_o,
  output logic [DATA_W-1:0] modem_data_o,
  output logic receiver_power_o,
  output logic ext_gate_o,
  output logic modem_gate_o,
  output logic power_lock_o
);

  // Clamp a 5-bit setting into its legal range
  function automatic logic [4:0] clamp5(input logic [4:0] v, input logic [4:0] lo,
                                        input logic [4:0] hi);
    clamp5 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Busy pin comes from the radio side, so it is synchronised
  logic busy_meta;
  logic busy_sync;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_meta <= 1'b0;
      busy_sync <= 1'b0;
    end else begin
      busy_meta <= radio_busy_i;
      busy_sync <= busy_meta;
    end
  end

  // (R3) delay setting decode
  wire [4:0] delay_sel = (startup_delay_sel_i > DELAY_SEL_MAX) ? DELAY_SEL_MAX
                                                               : startup_delay_sel_i;
  wire [PHASE_W-1:0] delay_s = DELAY_MIN_S + PHASE_W'(delay_sel * DELAY_STEP_S);
  // (R4) window setting decode
  wire [PHASE_W-1:0] window_s = PHASE_W'(clamp5(output_window_length_i, WINDOW_MIN_S,
                                                WINDOW_MAX_S));
  // (R9) report period decode
  wire [4:0] period_h = clamp5(report_period_i, PERIOD_MIN_H, PERIOD_MAX_H);
  // Widen both factors first: a full day of seconds overflows the 12-bit hour constant
  wire [CYCLE_W-1:0] period_s = CYCLE_W'(period_h) * CYCLE_W'(SEC_PER_HOUR);

  // (R10) command decode
  wire cmd_on = cmd_valid_i && (cmd_code_i == CMD_POWER_ON);
  wire cmd_off = cmd_valid_i && (cmd_code_i == CMD_POWER_OFF);
  wire cmd_open = cmd_valid_i && (cmd_code_i == CMD_OUTPUT_OPEN);
  wire cmd_modem = cmd_valid_i && (cmd_code_i == CMD_MODEM_OPEN);
  wire cmd_close = cmd_valid_i && (cmd_code_i == CMD_OUTPUT_CLOSE);

  gpsds_state_t state;
  gpsds_state_t next_state;
  logic power;
  logic ext_open;
  logic modem_open;
  logic next_power;
  logic next_ext_open;
  logic next_modem_open;
  logic restart;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic [PHASE_W-1:0] phase_cnt;
  logic [CYCLE_W-1:0] cycle_cnt;

  wire phase_last_delay = tick && (phase_cnt == delay_s - PHASE_W'(1));
  wire phase_last_window = tick && (phase_cnt == window_s - PHASE_W'(1));
  wire cycle_last = tick && (cycle_cnt == period_s - CYCLE_W'(1));
  wire in_schedule = (state == ST_WAIT_RADIO) || (state == ST_DELAY) ||
                     (state == ST_WINDOW) || (state == ST_SLEEP);

  // (R22) one-second tick; restart aligns seconds to a wake-up
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (restart || tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= !restart;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
      tick <= 1'b0;
    end
  end

  // Schedule and command sequencing; commands take priority over the schedule
  always_comb begin
    next_state = state;
    next_power = power;
    next_ext_open = ext_open;
    next_modem_open = modem_open;
    restart = 1'b0;
    unique case (state)
      ST_IDLE: begin
        // (R21) automatic mode starts the schedule
        if (auto_mode_i) begin
          next_state = ST_WAIT_RADIO;
        end
      end
      ST_WAIT_RADIO: begin
        // (R8) hold wake-up while radio busy
        if (!busy_sync) begin
          next_state = ST_DELAY;
          next_power = 1'b1;
          restart = 1'b1;
        end
      end
      ST_DELAY: begin
        // (R2) output stays blocked during delay
        if (phase_last_delay) begin
          next_state = ST_WINDOW;
        end
      end
      ST_WINDOW: begin
        // (R5) window end sleeps receiver
        if (phase_last_window) begin
          next_state = ST_SLEEP;
          next_power = 1'b0;
        end
      end
      ST_SLEEP: begin
        // (R7) sleep for rest of cycle
        if (cycle_last) begin
          next_state = ST_WAIT_RADIO;
        end
      end
      ST_CMD_ON, ST_LOCKED: begin
        next_state = state;
      end
    endcase
    // (R21) manual mode leaves the schedule
    if (!auto_mode_i && in_schedule) begin
      next_state = ST_IDLE;
      next_power = 1'b0;
    end
    // (R11) power on with output closed
    if (cmd_on) begin
      next_power = 1'b1;
      next_ext_open = 1'b0;
      next_modem_open = 1'b0;
      next_state = ST_CMD_ON;
    end
    // (R12) power off, lock until open or power-on
    if (cmd_off) begin
      next_power = 1'b0;
      next_ext_open = 1'b0;
      next_modem_open = 1'b0;
      next_state = ST_LOCKED;
    end
    // (R13) open only when powered
    if (cmd_open && power) begin
      next_ext_open = 1'b1;
      // (R14) old firmware gates modem here
      next_modem_open = !fw_new_i;
      next_state = ST_CMD_ON;
    end else if (cmd_open && state == ST_LOCKED) begin
      // (R20) open command releases the lock
      next_state = ST_IDLE;
    end
    // (R18) modem forwarding, new firmware only
    if (cmd_modem && power && fw_new_i) begin
      next_modem_open = 1'b1;
      next_ext_open = 1'b0;
      next_state = ST_CMD_ON;
    end
    // (R15) close acts only while powered
    if (cmd_close && power) begin
      next_ext_open = 1'b0;
      next_modem_open = 1'b0;
      // (R19) resume schedule from fresh timers
      next_state = auto_mode_i ? ST_WAIT_RADIO : ST_CMD_ON;
    end
    // (R16) no power means closed path
    if (!next_power) begin
      next_ext_open = 1'b0;
      next_modem_open = 1'b0;
    end
  end

  // Controller state and gate registers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      power <= 1'b0;
      ext_open <= 1'b0;
      modem_open <= 1'b0;
    end else begin
      state <= next_state;
      power <= next_power;
      ext_open <= next_ext_open;
      modem_open <= next_modem_open;
    end
  end

  // (R6) every wake-up restarts phase timing
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_cnt <= '0;
      cycle_cnt <= '0;
    end else if (restart || next_state != state) begin
      phase_cnt <= '0;
      cycle_cnt <= restart ? '0 : cycle_cnt + CYCLE_W'(tick);
    end else if (tick) begin
      phase_cnt <= phase_cnt + PHASE_W'(1);
      cycle_cnt <= cycle_cnt + CYCLE_W'(1);
    end
  end

  // (R17) window or open command feeds the external port
  wire next_ext_gate = next_power && (next_ext_open || next_state == ST_WINDOW);
  // (R14) automatic reports and the modem command feed the modem
  wire next_modem_gate = next_power && (next_modem_open || next_state == ST_WINDOW);

  // Status outputs, registered
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      receiver_power_o <= 1'b0;
      ext_gate_o <= 1'b0;
      modem_gate_o <= 1'b0;
      power_lock_o <= 1'b0;
    end else begin
      receiver_power_o <= next_power;
      ext_gate_o <= next_ext_gate;
      modem_gate_o <= next_modem_gate;
      power_lock_o <= (next_state == ST_LOCKED);
    end
  end

  // Two-entry buffer between the receiver and the output ports
  logic [DATA_W-1:0] fifo_mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic [1:0] out_valid;
  logic [DATA_W-1:0] out_data [2];
  wire [1:0] out_gate = {modem_gate_o, ext_gate_o};
  wire [1:0] out_ready = {modem_ready_i, ext_ready_i};
  wire [1:0] out_free = ~out_valid | out_ready;
  wire push = rx_valid_i && rx_ready_o;
  // A word leaves only when every open port can take it; closed ports drop it
  wire pop = (count != 2'h0) && ((out_free | ~out_gate) == 2'h3);
  wire [1:0] next_count = count + 2'(push) - 2'(pop);
  wire [DATA_W-1:0] head = fifo_mem[rd_ptr];

  // Ready is registered from the next fill level, so a full buffer stalls the source
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      rx_ready_o <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count <= next_count;
      rx_ready_o <= (next_count != FIFO_DEPTH);
    end
  end

  // Storage needs no reset; only valid bits matter
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      fifo_mem[wr_ptr] <= rx_data_i;
    end
  end

  // Output stage per port; holds until the sink accepts
  for (genvar p = 0; p < 2; p++) begin : g_out
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        out_valid[p] <= 1'b0;
        out_data[p] <= '0;
      end else if (pop && out_gate[p]) begin
        out_valid[p] <= 1'b1;
        out_data[p] <= head;
      end else if (out_ready[p]) begin
        out_valid[p] <= 1'b0;
      end
    end
  end

  assign ext_valid_o = out_valid[PORT_EXT];
  assign ext_data_o = out_data[PORT_EXT];
  assign modem_valid_o = out_valid[PORT_MODEM];
  assign modem_data_o = out_data[PORT_MODEM];

endmodule // gpsds_top

// file: tb/gpsds_checker_assertions.sv
// Port checker for the receiver power and data scheduler
`timescale 1ns/1ps
module gpsds_checker
  import gpsds_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic fw_new_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_code_i,
  input wire logic ext_ready_i,
  input wire logic ext_valid_o,
  input wire logic [DATA_W-1:0] ext_data_o,
  input wire logic receiver_power_o,
  input wire logic ext_gate_o,
  input wire logic modem_gate_o,
  input wire logic power_lock_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Command decode, one wire per code
  wire c_on = cmd_valid_i && cmd_code_i == CMD_POWER_ON;
  wire c_off = cmd_valid_i && cmd_code_i == CMD_POWER_OFF;
  wire c_open = cmd_valid_i && cmd_code_i == CMD_OUTPUT_OPEN;
  wire c_modem = cmd_valid_i && cmd_code_i == CMD_MODEM_OPEN;
  wire c_close = cmd_valid_i && cmd_code_i == CMD_OUTPUT_CLOSE;
  // Gates and power relations, answers one cycle after the command
  AST_GATE_POWERED: assert property ((ext_gate_o || modem_gate_o) |-> receiver_power_o)
    else $error("gate open while unpowered");
  AST_LOCK_DARK: assert property (power_lock_o |-> !receiver_power_o && !ext_gate_o)
    else $error("locked but powered");
  AST_ON_CLOSED: assert property (c_on && !receiver_power_o && !power_lock_o
    |=> receiver_power_o && !ext_gate_o && !modem_gate_o)
    else $error("power on opened output");
  AST_OFF_ALL: assert property (c_off |=> power_lock_o && !receiver_power_o && !modem_gate_o)
    else $error("power off not applied");
  AST_OPEN_EXT: assert property (c_open && receiver_power_o
    |=> ext_gate_o && modem_gate_o == !$past(fw_new_i))
    else $error("open command gating wrong");
  AST_OPEN_DARK: assert property (c_open && !receiver_power_o |=> !ext_gate_o)
    else $error("output opened unpowered");
  AST_MODEM_OPEN: assert property (c_modem && receiver_power_o && fw_new_i |=> modem_gate_o)
    else $error("modem path not opened");
  AST_CLOSE_ALL: assert property (c_close && receiver_power_o |=> !ext_gate_o && !modem_gate_o)
    else $error("close left a path open");
  AST_EXT_HOLD: assert property (ext_valid_o && !ext_ready_i |=> ext_valid_o && $stable(ext_data_o))
    else $error("external word lost in stall");
endmodule // gpsds_checker

bind gpsds_top gpsds_checker i_gpsds_checker (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
  .fw_new_i(fw_new_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
  .ext_ready_i(ext_ready_i), .ext_valid_o(ext_valid_o), .ext_data_o(ext_data_o),
  .receiver_power_o(receiver_power_o), .ext_gate_o(ext_gate_o),
  .modem_gate_o(modem_gate_o), .power_lock_o(power_lock_o));

// file: tb/gpsds_engine.sv
// Behavioural receiver engine that emits sentence bytes
`timescale 1ns/1ps
module gpsds_engine
  import gpsds_pkg::*;
#(
  parameter int TICK_CYCLES = 10,
  parameter int SET_LEN = 4
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic power_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [DATA_W-1:0] rx_data_o
);
  int tick_cnt;
  int left;
  logic [DATA_W-1:0] seq;
  // A burst starts at power-up and at each tick; a released line shows inverted data
  // set per second
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt <= 0;
      left <= 0;
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'h00;
      seq <= 8'h00;
    end else if (!power_i) begin
      tick_cnt <= 0;
      left <= 0;
      rx_valid_o <= 1'b0;
      rx_data_o <= ~rx_data_o;
    end else begin
      tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 0 : tick_cnt + 1;
      if (rx_valid_o && rx_ready_i) begin
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
        seq <= seq + 8'h01;
      end else if (!rx_valid_o && left > 0) begin
        rx_valid_o <= 1'b1;
        rx_data_o <= seq;
        left <= left - 1;
      end
      if (tick_cnt == 0) begin
        left <= SET_LEN;
      end
    end
  end
endmodule // gpsds_engine

// file: tb/tb.sv
// Self-checking bench for the receiver scheduler
`timescale 1ns/1ps
module tb;
  import gpsds_pkg::*;
  localparam int TK = 10;
  localparam int DLY = 50 * TK;
  localparam int DLY_MAX = 300 * TK;
  localparam int WIN = 10 * TK;
  localparam int PER = 3600 * TK;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic auto_mode = 1'b0;
  logic fw_new = 1'b0;
  logic busy = 1'b1;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_code = 3'h0;
  logic [4:0] delay_sel = 5'h00;
  logic ext_ready = 1'b0;
  logic modem_ready = 1'b1;
  logic rx_valid, rx_ready, ext_valid, modem_valid, power, ext_gate, modem_gate, lock;
  logic [7:0] rx_data, ext_data, modem_data;
  int err_count = 0;
  int samples_checked = 0;

  gpsds_top #(.TICK_CYCLES(TK)) i_gpsds_top (.ref_clk_i(clk), .reset_n_i(rst_n),
    .auto_mode_i(auto_mode), .fw_new_i(fw_new), .radio_busy_i(busy),
    .startup_delay_sel_i(delay_sel), .output_window_length_i(5'h0c), .report_period_i(5'h01),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .ext_ready_i(ext_ready), .modem_ready_i(modem_ready),
    .rx_ready_o(rx_ready), .ext_valid_o(ext_valid), .ext_data_o(ext_data),
    .modem_valid_o(modem_valid), .modem_data_o(modem_data), .receiver_power_o(power),
    .ext_gate_o(ext_gate), .modem_gate_o(modem_gate), .power_lock_o(lock));
  gpsds_engine #(.TICK_CYCLES(TK)) i_gpsds_engine (.ref_clk_i(clk), .reset_n_i(rst_n),
    .power_i(power), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data));

  // Free running 100 MHz clock
  always #5 clk = ~clk;

  task automatic check(input bit ok, input string what);
    samples_checked++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask

  task automatic give_verdict;
    $display("Errors %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic pick(input int s);
    return (s == 0) ? power : ext_gate;
  endfunction

  // Counts cycles until a level shows; bounded so a hang cannot stall the run
  task automatic wait_lvl(input int s, input logic lvl, output int n);
    n = 0;
    while (pick(s) !== lvl && n < 40000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic do_cmd(input logic f, input logic [2:0] c);
    @(posedge clk);
    #1 fw_new = f;
    cmd_valid = 1'b1;
    cmd_code = c;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  // Schedule: busy hold-off, delay, clamped window, sleep, hourly period, second wake
  task automatic t_auto;
    int n;
    int tot;
    @(posedge clk);
    #1 auto_mode = 1'b1;
    repeat (100) @(negedge clk);
    check(power === 1'b0, "woke while radio busy");
    @(posedge clk);
    #1 busy = 1'b0;
    wait_lvl(0, 1'b1, n);
    check(n <= 5, "late wake after busy");
    wait_lvl(1, 1'b1, tot);
    check(tot >= DLY - 2 && tot <= DLY + 2, "start-up delay length");
    wait_lvl(1, 1'b0, n);
    tot += n;
    check(n >= WIN - 2 && n <= WIN + 2, "window length");
    wait_lvl(0, 1'b0, n);
    tot += n;
    check(n <= 2, "no sleep after window");
    wait_lvl(0, 1'b1, n);
    tot += n;
    check(tot >= PER - 3 && tot <= PER + 3, "report period");
    wait_lvl(1, 1'b1, n);
    check(n >= DLY - 2 && n <= DLY + 2, "delay not reapplied");
    @(posedge clk);
    #1 auto_mode = 1'b0;
    repeat (3) @(negedge clk);
    check(power === 1'b0 && ext_gate === 1'b0, "manual mode kept power");
  endtask

  // Command table: expected {lock, power, ext gate, modem gate} after each
  task automatic t_cmds;
    logic [2:0] code [10] = '{CMD_POWER_ON, CMD_OUTPUT_OPEN, CMD_OUTPUT_CLOSE, CMD_MODEM_OPEN,
      CMD_MODEM_OPEN, CMD_OUTPUT_OPEN, 3'h7, CMD_POWER_OFF, CMD_OUTPUT_CLOSE, CMD_OUTPUT_OPEN};
    logic [3:0] exp [10] = '{4'h4, 4'h7, 4'h4, 4'h4, 4'h5, 4'h6, 4'h6, 4'h8, 4'h8, 4'h0};
    logic [9:0] fw = 10'h3f0;
    for (int i = 0; i < 10; i++) begin
      do_cmd(fw[i], code[i]);
      check({lock, power, ext_gate, modem_gate} === exp[i], "command response");
    end
  endtask

  // Out-of-range delay clamps to 300 s; a close in auto mode restarts the timers
  task automatic t_clamp;
    int n;
    @(posedge clk);
    #1 auto_mode = 1'b1;
    delay_sel = 5'h1f;
    do_cmd(1'b1, CMD_POWER_ON);
    do_cmd(1'b1, CMD_OUTPUT_CLOSE);
    check(power === 1'b1 && ext_gate === 1'b0, "close dropped power");
    wait_lvl(1, 1'b1, n);
    check(n >= DLY_MAX - 2 && n <= DLY_MAX + 2, "clamped delay length");
    @(posedge clk);
    #1 auto_mode = 1'b0;
    delay_sel = 5'h00;
    repeat (3) @(negedge clk);
  endtask

  // Stream: stall until the buffer refuses, then drain with a toggling sink
  task automatic t_stream;
    int n;
    bit have;
    bit seen_modem;
    logic [7:0] last;
    // Drain any word still standing at the external port, so the order check starts clean
    @(posedge clk);
    #1 ext_ready = 1'b1;
    @(posedge clk);
    #1 ext_ready = 1'b0;
    do_cmd(1'b0, CMD_POWER_ON);
    do_cmd(1'b0, CMD_OUTPUT_OPEN);
    repeat (40) @(negedge clk);
    check(rx_ready === 1'b0 && ext_valid === 1'b1, "stall not held");
    n = 0;
    have = 1'b0;
    seen_modem = 1'b0;
    for (int k = 0; k < 200 && n < 8; k++) begin
      @(posedge clk);
      #1 ext_ready = k[0];
      @(negedge clk);
      if (ext_valid === 1'b1 && ext_ready) begin
        if (have) check(ext_data === last + 8'h01, "word order");
        check(modem_data === ext_data, "modem copy differs");
        last = ext_data;
        have = 1'b1;
        n++;
      end
      seen_modem |= (modem_valid === 1'b1);
    end
    check(n == 8, "stream stalled");
    check(seen_modem, "modem path idle");
    do_cmd(1'b0, CMD_POWER_OFF);
  endtask

  // Main sequence after a five cycle reset
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    t_auto();
    t_cmds();
    t_clamp();
    t_stream();
    give_verdict();
  end

  // Watchdog well beyond the expected 40000 cycles
  initial begin
    #500000;
    err_count++;
    give_verdict();
  end
endmodule // tb
